//--- shared/gpp_pkg.sv
/*
  Constants for the GPIO port block: register offsets, field positions,
  widths and reset values.
  Assumes a 32-bit APB bus with byte addresses and one register per word.
*/
package gpp_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_DRIVE_SEL  = 8'h00;
  localparam logic [7:0] OFS_IRQ_SC     = 8'h04;
  localparam logic [7:0] OFS_PIN_SEL    = 8'h08;
  localparam logic [7:0] OFS_EDGE_SEL   = 8'h0c;
  localparam logic [7:0] OFS_B_DATA     = 8'h10;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h14;
  localparam logic [7:0] OFS_EVT_MASK   = 8'h18;

  // Widths
  localparam int DRV_W  = 5;
  localparam int IRQ_W  = 4;
  localparam int PA_W   = 6;
  localparam int PB_W   = 8;
  localparam int EVT_W  = 2;

  // Status/control field positions
  localparam int SC_FLAG = 3;
  localparam int SC_ACK  = 2;
  localparam int SC_IE   = 1;
  localparam int SC_MOD  = 0;

  // Event status field positions
  localparam int EVT_DETECT = 0;
  localparam int EVT_FLAG   = 1;

  // Values after reset
  localparam logic [DRV_W-1:0] RST_DRIVE_SEL = 5'h00;
  localparam logic [IRQ_W-1:0] RST_PIN_SEL   = 4'h0;
  localparam logic [IRQ_W-1:0] RST_EDGE_SEL  = 4'h0;
  localparam logic [PB_W-1:0]  RST_B_DATA    = 8'h00;
  localparam logic [EVT_W-1:0] RST_EVT       = 2'h0;

  // Cycles of the synchroniser before a pin level is usable
  localparam int SYNC_STAGES = 2;

endpackage

//--- src/gpp_port.sv
/*
  GPIO port block: first-port drive select and pin interrupt detector,
  second-port data register, APB register slave and event interrupt.
  Assumes pins synchronous to clk_sys only through the internal
  synchroniser, and direction and pull-enable bits supplied by the
  neighbouring port control registers.
*/
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps

// Operation
// - Drive bits 4:0 pick high drive
// - Drive bit 5 ignores writes
// - Flag set on detect, writes ignored
// - Ack write clears flag, reads zero
// - Enable bit gates interrupt request
// - Mode bit: edges only or levels
// - Pin select includes pin as source
// - Edge select 0: pull-up, falling/low
// - Edge select 1: pull-down, rising/high
// - Pull polarity only with pull enable
// - Input pin reads sampled level
// - Output pin reads stored data
// - Writes stored always, outputs driven
// - Reset clears data, pins Hi-Z
// - Direction selects driver and read source
// - No pull on output pins
// - Pull-down only for interrupt pins
module gpp_port (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [31:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  output logic                           irq,
  input  wire logic [gpp_pkg::PA_W-1:0]  first_port_direction,
  input  wire logic [gpp_pkg::IRQ_W-1:0] first_port_pull_enable,
  input  wire logic [gpp_pkg::IRQ_W-1:0] first_port_pins_in,
  output logic      [gpp_pkg::DRV_W-1:0] first_port_drive_high,
  output logic      [gpp_pkg::IRQ_W-1:0] first_port_pull_up_en,
  output logic      [gpp_pkg::IRQ_W-1:0] first_port_pull_down_en,
  output logic                           first_port_irq_request,
  input  wire logic [gpp_pkg::PB_W-1:0]  second_port_direction,
  input  wire logic [gpp_pkg::PB_W-1:0]  second_port_pins_in,
  output logic      [gpp_pkg::PB_W-1:0]  second_port_pins_out,
  output logic      [gpp_pkg::PB_W-1:0]  second_port_pins_oe
);

  logic [gpp_pkg::DRV_W-1:0] drive_sel_reg;
  logic                      irq_flag_reg;
  logic                      irq_enable_reg;
  logic                      detect_mode_reg;
  logic [gpp_pkg::IRQ_W-1:0] pin_sel_reg;
  logic [gpp_pkg::IRQ_W-1:0] edge_sel_reg;
  logic [gpp_pkg::PB_W-1:0]  b_data_reg;
  logic [gpp_pkg::EVT_W-1:0] evt_status_reg;
  logic [gpp_pkg::EVT_W-1:0] evt_mask_reg;
  logic [gpp_pkg::EVT_W-1:0] evt_status_next;
  logic                      irq_flag_next;
  logic [gpp_pkg::IRQ_W-1:0] a_sync1_reg;
  logic [gpp_pkg::IRQ_W-1:0] a_sync2_reg;
  logic [gpp_pkg::IRQ_W-1:0] a_prev_reg;
  logic [gpp_pkg::PB_W-1:0]  b_sync1_reg;
  logic [gpp_pkg::PB_W-1:0]  b_sync2_reg;
  logic [gpp_pkg::IRQ_W-1:0] level_act;
  logic [gpp_pkg::IRQ_W-1:0] edge_act;
  logic [gpp_pkg::IRQ_W-1:0] pin_trig;
  logic                      detect;
  logic                      level_hold;
  logic                      acc;
  logic                      wr_en;
  logic                      ack_wr;
  logic [gpp_pkg::PB_W-1:0]  b_read;
  logic [31:0]               rd_mux;
  logic                      rd_hit;

  // True when the byte address matches a register offset
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] ofs);
    hit = (addr[31:8] == 24'h000000) && (addr[7:0] == ofs);
  endfunction

  // Active trigger level for a pin given its edge select
  function automatic logic [gpp_pkg::IRQ_W-1:0] active_level(input logic [gpp_pkg::IRQ_W-1:0] smp,
                                                            input logic [gpp_pkg::IRQ_W-1:0] es);
    active_level = (smp & es) | (~smp & ~es);
  endfunction

  // APB: one wait state, answer registered
  assign acc    = psel && penable && pready;
  assign wr_en  = acc && pwrite && pstrb[0];
  assign ack_wr = wr_en && hit(paddr, gpp_pkg::OFS_IRQ_SC) && pwdata[gpp_pkg::SC_ACK];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
    end
  end

  // Pin synchronisers; edge compare uses the second stage and its delayed copy a_prev_reg
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      a_sync1_reg <= '0;
      a_sync2_reg <= '0;
      a_prev_reg  <= '0;
      b_sync1_reg <= '0;
      b_sync2_reg <= '0;
    end else begin
      a_sync1_reg <= first_port_pins_in;
      a_sync2_reg <= a_sync1_reg;
      a_prev_reg  <= a_sync2_reg;
      b_sync1_reg <= second_port_pins_in;
      b_sync2_reg <= b_sync1_reg;
    end
  end

  // Trigger detection per pin
  always_comb begin
    level_act = active_level(a_sync2_reg, edge_sel_reg);
    edge_act  = level_act & ~active_level(a_prev_reg, edge_sel_reg);
    pin_trig  = pin_sel_reg & (edge_act | (detect_mode_reg ? level_act : '0));
    detect    = |pin_trig;
    level_hold = detect_mode_reg && |(pin_sel_reg & level_act);
  end

  // Flag: detection wins over acknowledge; plain writes ignored
  always_comb begin
    irq_flag_next = irq_flag_reg;
    if (detect) begin
      irq_flag_next = 1'b1;
    end else if (ack_wr && !level_hold) begin
      irq_flag_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_flag_reg <= 1'b0;
    end else begin
      irq_flag_reg <= irq_flag_next;
    end
  end

  // Control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      drive_sel_reg   <= gpp_pkg::RST_DRIVE_SEL;
      irq_enable_reg  <= 1'b0;
      detect_mode_reg <= 1'b0;
      pin_sel_reg     <= gpp_pkg::RST_PIN_SEL;
      edge_sel_reg    <= gpp_pkg::RST_EDGE_SEL;
      evt_mask_reg    <= gpp_pkg::RST_EVT;
    end else if (wr_en) begin
      if (hit(paddr, gpp_pkg::OFS_DRIVE_SEL)) begin
        drive_sel_reg <= pwdata[gpp_pkg::DRV_W-1:0];
      end
      if (hit(paddr, gpp_pkg::OFS_IRQ_SC)) begin
        irq_enable_reg  <= pwdata[gpp_pkg::SC_IE];
        detect_mode_reg <= pwdata[gpp_pkg::SC_MOD];
      end
      if (hit(paddr, gpp_pkg::OFS_PIN_SEL)) begin
        pin_sel_reg <= pwdata[gpp_pkg::IRQ_W-1:0];
      end
      if (hit(paddr, gpp_pkg::OFS_EDGE_SEL)) begin
        edge_sel_reg <= pwdata[gpp_pkg::IRQ_W-1:0];
      end
      if (hit(paddr, gpp_pkg::OFS_EVT_MASK)) begin
        evt_mask_reg <= pwdata[gpp_pkg::EVT_W-1:0];
      end
    end
  end

  // Second port data: every write stored whatever the direction
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      b_data_reg <= gpp_pkg::RST_B_DATA;
    end else if (wr_en && hit(paddr, gpp_pkg::OFS_B_DATA)) begin
      b_data_reg <= pwdata[gpp_pkg::PB_W-1:0];
    end
  end

  // Event status: set wins over write-one-to-clear
  always_comb begin
    evt_status_next = evt_status_reg;
    if (wr_en && hit(paddr, gpp_pkg::OFS_EVT_STATUS)) begin
      evt_status_next = evt_status_reg & ~pwdata[gpp_pkg::EVT_W-1:0];
    end
    if (detect) begin
      evt_status_next[gpp_pkg::EVT_DETECT] = 1'b1;
    end
    if (irq_flag_next && !irq_flag_reg) begin
      evt_status_next[gpp_pkg::EVT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evt_status_reg <= gpp_pkg::RST_EVT;
      irq            <= 1'b0;
    end else begin
      evt_status_reg <= evt_status_next;
      irq            <= |(evt_status_next & evt_mask_reg);
    end
  end

  // Read multiplexer
  always_comb begin
    b_read = (second_port_direction & b_data_reg) | (~second_port_direction & b_sync2_reg);
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    if (hit(paddr, gpp_pkg::OFS_DRIVE_SEL)) begin
      rd_mux[gpp_pkg::DRV_W-1:0] = drive_sel_reg;
    end else if (hit(paddr, gpp_pkg::OFS_IRQ_SC)) begin
      rd_mux[gpp_pkg::SC_FLAG] = irq_flag_reg;
      rd_mux[gpp_pkg::SC_IE]   = irq_enable_reg;
      rd_mux[gpp_pkg::SC_MOD]  = detect_mode_reg;
    end else if (hit(paddr, gpp_pkg::OFS_PIN_SEL)) begin
      rd_mux[gpp_pkg::IRQ_W-1:0] = pin_sel_reg;
    end else if (hit(paddr, gpp_pkg::OFS_EDGE_SEL)) begin
      rd_mux[gpp_pkg::IRQ_W-1:0] = edge_sel_reg;
    end else if (hit(paddr, gpp_pkg::OFS_B_DATA)) begin
      rd_mux[gpp_pkg::PB_W-1:0] = b_read;
    end else if (hit(paddr, gpp_pkg::OFS_EVT_STATUS)) begin
      rd_mux[gpp_pkg::EVT_W-1:0] = evt_status_reg;
    end else if (hit(paddr, gpp_pkg::OFS_EVT_MASK)) begin
      rd_mux[gpp_pkg::EVT_W-1:0] = evt_mask_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= !rd_hit;
    end else begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // Pin side outputs, all registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      first_port_drive_high   <= '0;
      first_port_pull_up_en   <= '0;
      first_port_pull_down_en <= '0;
      first_port_irq_request  <= 1'b0;
      second_port_pins_out    <= '0;
      second_port_pins_oe     <= '0;
    end else begin
      first_port_drive_high   <= drive_sel_reg & first_port_direction[gpp_pkg::DRV_W-1:0];
      first_port_pull_up_en   <= first_port_pull_enable & ~first_port_direction[gpp_pkg::IRQ_W-1:0]
                                 & ~edge_sel_reg;
      first_port_pull_down_en <= first_port_pull_enable & ~first_port_direction[gpp_pkg::IRQ_W-1:0]
                                 & edge_sel_reg & pin_sel_reg;
      first_port_irq_request  <= irq_flag_next && irq_enable_reg;
      second_port_pins_out    <= b_data_reg;
      second_port_pins_oe     <= second_port_direction;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_DRIVE_INPUT_LOW: assert property (
    1'b1 |=> ((first_port_drive_high & ~$past(first_port_direction[gpp_pkg::DRV_W-1:0])) == '0))
    else $error("High drive on an input pin");

  AST_DRIVE_BIT5_READ_ZERO: assert property (
    (psel && penable && !pready && !pwrite && hit(paddr, gpp_pkg::OFS_DRIVE_SEL)) |=> (pready && !prdata[5]))
    else $error("Unused drive bit read as one");

  AST_FLAG_WRITE_IGNORED: assert property (
    (irq_flag_reg && wr_en && hit(paddr, gpp_pkg::OFS_IRQ_SC) && !pwdata[gpp_pkg::SC_ACK]) |=> irq_flag_reg)
    else $error("Plain write altered the flag");

  AST_ACK_READS_ZERO: assert property (
    (psel && penable && !pready && !pwrite && hit(paddr, gpp_pkg::OFS_IRQ_SC)) |=> !prdata[gpp_pkg::SC_ACK])
    else $error("Acknowledge bit read as one");

  AST_ACK_CLEARS: assert property (
    (ack_wr && !detect && !level_hold) |=> !irq_flag_reg)
    else $error("Acknowledge did not clear the flag");

  AST_REQ_GATED: assert property (
    (!irq_enable_reg) |=> !first_port_irq_request)
    else $error("Request raised while disabled");

  AST_DETECT_SETS: assert property (
    detect |=> (irq_flag_reg ##0 (first_port_irq_request == $past(irq_enable_reg))))
    else $error("Detection did not set the flag");

  AST_EXCLUDED_PIN: assert property (
    (pin_sel_reg == '0) |-> !detect)
    else $error("Detection with no pin selected");

  AST_FALL_TRIGGERS: assert property (
    (pin_sel_reg[0] && !edge_sel_reg[0] && $fell(first_port_pins_in[0]) && !wr_en)
      ##1 (!first_port_pins_in[0] && !wr_en) [*3] |=> irq_flag_reg)
    else $error("Falling edge missed");

  AST_PULL_DOWN_ONLY_IRQ: assert property (
    1'b1 |=> ((first_port_pull_down_en & ~$past(pin_sel_reg & edge_sel_reg)) == '0))
    else $error("Pull-down on a non-interrupt pin");

  AST_NO_PULL_OUTPUT: assert property (
    1'b1 |=> (((first_port_pull_up_en | first_port_pull_down_en)
               & $past(first_port_direction[gpp_pkg::IRQ_W-1:0])) == '0))
    else $error("Pull enabled on an output pin");

  AST_LEVEL_HOLDS_FLAG: assert property (
    (ack_wr && level_hold) |=> irq_flag_reg)
    else $error("Flag cleared while level still asserted");

  AST_READ_SOURCE: assert property (
    (psel && penable && !pready && !pwrite && hit(paddr, gpp_pkg::OFS_B_DATA))
      |=> (prdata[gpp_pkg::PB_W-1:0] == $past(b_read)) && (prdata[31:gpp_pkg::PB_W] == '0))
    else $error("Data read from wrong source");

  AST_RESET_HIZ: assert property (
    $past(rst) |-> (second_port_pins_oe == '0 && first_port_pull_up_en == '0 && b_data_reg == '0))
    else $error("Pins not high impedance after reset");

  COV_EDGE_DETECT: cover property (!detect_mode_reg && detect ##1 irq_flag_reg);
  COV_LEVEL_HOLD:  cover property (ack_wr && level_hold);
  COV_ACK_CLEAR:   cover property (irq_flag_reg && ack_wr ##1 !irq_flag_reg);
  COV_IRQ_OUT:     cover property (!irq ##1 irq);

endmodule

//--- bench/gpp_pins_model.sv
/*
  Model of the circuitry on the port pins.
  Assumes the bench sets the external source levels; the block's
  own driver takes over a second-port pin while its enable is high.
*/
`timescale 1ns/1ps

module gpp_pins_model (
  input  wire logic [gpp_pkg::IRQ_W-1:0] ext_a,
  input  wire logic [gpp_pkg::PB_W-1:0]  ext_b,
  input  wire logic [gpp_pkg::PB_W-1:0]  out_b,
  input  wire logic [gpp_pkg::PB_W-1:0]  oe_b,
  output logic      [gpp_pkg::IRQ_W-1:0] pins_a,
  output logic      [gpp_pkg::PB_W-1:0]  pins_b
);
  assign pins_a = ext_a;
  // Driven pins show the stored level, others the outside source
  assign pins_b = (oe_b & out_b) | (~oe_b & ext_b);
endmodule

//--- bench/gpp_port_tb.sv
/*
  Self-checking bench for the GPIO port block: APB register tests,
  pin outputs and pin interrupt sequences.
  Assumes the pins model as the only source of pin levels.
*/
`timescale 1ns/1ps

module gpp_port_tb;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] paddr   = 32'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'h0;
  logic [5:0]  dir_a   = 6'h00;
  logic [3:0]  pe_a    = 4'h0;
  logic [7:0]  dir_b   = 8'h00;
  logic [3:0]  ext_a   = 4'hf;
  logic [7:0]  ext_b   = 8'h5a;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, req;
  logic [4:0]  drv_hi;
  logic [3:0]  pins_a, pu, pd;
  logic [7:0]  pins_b, out_b, oe_b;
  int          num_errors = 0;
  int          checked    = 0;
  logic [7:0]  reset_ofs[6] = '{gpp_pkg::OFS_DRIVE_SEL, gpp_pkg::OFS_IRQ_SC, gpp_pkg::OFS_PIN_SEL,
                                gpp_pkg::OFS_EDGE_SEL, gpp_pkg::OFS_EVT_STATUS, gpp_pkg::OFS_EVT_MASK};

  gpp_port i_gpp_port (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .first_port_direction(dir_a), .first_port_pull_enable(pe_a), .first_port_pins_in(pins_a),
    .first_port_drive_high(drv_hi), .first_port_pull_up_en(pu), .first_port_pull_down_en(pd),
    .first_port_irq_request(req), .second_port_direction(dir_b), .second_port_pins_in(pins_b),
    .second_port_pins_out(out_b), .second_port_pins_oe(oe_b));

  gpp_pins_model i_gpp_pins_model (.ext_a(ext_a), .ext_b(ext_b), .out_b(out_b), .oe_b(oe_b),
    .pins_a(pins_a), .pins_b(pins_b));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                          input logic [3:0] strb, output logic [31:0] rdata, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {24'h0, addr};
    pwdata <= wdata;
    pstrb <= strb;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Request held until pready is seen at a rising edge; the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] strb = 4'h1);
    logic [31:0] d;
    logic        e;
    apb_xfer(1'b1, addr, data, strb, d, e);
  endtask

  task automatic check_read(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err = 1'b0);
    logic [31:0] d;
    logic        e;
    apb_xfer(1'b0, addr, 32'h0, 4'h0, d, e);
    checked++;
    if (d !== exp || e !== exp_err) begin
      num_errors++;
      $display("unexpected read at %0t: got %h err %h, expected %h err %h", $time, d, e, exp, exp_err);
    end
  endtask

  task automatic check_pin(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected output at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  initial begin
    #200000;
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    settle(0);
    check_pin(32'(oe_b), 32'h0);
    check_pin(32'(out_b), 32'h0);
    check_pin(32'(pu | pd), 32'h0);
    check_pin(32'({req, irq}), 32'h0);
    foreach (reset_ofs[i]) check_read(reset_ofs[i], 32'h0);
    check_read(gpp_pkg::OFS_B_DATA, 32'h5a);
    end_test("reset");

    @(posedge clk_sys);
    dir_a <= 6'h0a;
    reg_write(gpp_pkg::OFS_DRIVE_SEL, 32'h3f);
    check_read(gpp_pkg::OFS_DRIVE_SEL, 32'h1f);
    settle(1);
    check_pin(32'(drv_hi), 32'h0a);
    reg_write(gpp_pkg::OFS_DRIVE_SEL, 32'h00, 4'h0);
    check_read(gpp_pkg::OFS_DRIVE_SEL, 32'h1f);
    check_read(8'h1c, 32'h0, 1'b1);
    end_test("drive");

    reg_write(gpp_pkg::OFS_EDGE_SEL, 32'h5);
    reg_write(gpp_pkg::OFS_PIN_SEL, 32'h3);
    @(posedge clk_sys);
    dir_a <= 6'h00;
    pe_a <= 4'hf;
    settle(2);
    check_pin(32'(pu), 32'ha);
    check_pin(32'(pd), 32'h1);
    @(posedge clk_sys);
    dir_a <= 6'h03;
    settle(2);
    check_pin(32'({pu, pd}), 32'h80);
    @(posedge clk_sys);
    pe_a <= 4'h0;
    settle(2);
    check_pin(32'({pu, pd}), 32'h00);
    end_test("pulls");

    reg_write(gpp_pkg::OFS_B_DATA, 32'hc3);
    settle(1);
    check_pin(32'({oe_b, out_b}), 32'h00c3);
    check_read(gpp_pkg::OFS_B_DATA, 32'h5a);
    @(posedge clk_sys);
    dir_b <= 8'hf0;
    settle(3);
    check_pin(32'(oe_b), 32'hf0);
    check_read(gpp_pkg::OFS_B_DATA, 32'hca);
    @(posedge clk_sys);
    dir_b <= 8'hff;
    ext_b <= 8'h00;
    settle(3);
    check_read(gpp_pkg::OFS_B_DATA, 32'hc3);
    end_test("data");

    @(posedge clk_sys);
    dir_a <= 6'h00;
    reg_write(gpp_pkg::OFS_EVT_MASK, 32'h3);
    reg_write(gpp_pkg::OFS_EDGE_SEL, 32'h0);
    reg_write(gpp_pkg::OFS_PIN_SEL, 32'h1);
    reg_write(gpp_pkg::OFS_IRQ_SC, 32'h02);
    @(posedge clk_sys);
    ext_a <= 4'he;
    settle(4);
    check_pin(32'({req, irq}), 32'h3);
    check_read(gpp_pkg::OFS_IRQ_SC, 32'h0a);
    check_read(gpp_pkg::OFS_EVT_STATUS, 32'h3);
    reg_write(gpp_pkg::OFS_IRQ_SC, 32'h02);
    check_read(gpp_pkg::OFS_IRQ_SC, 32'h0a);
    reg_write(gpp_pkg::OFS_IRQ_SC, 32'h06);
    check_read(gpp_pkg::OFS_IRQ_SC, 32'h02);
    settle(0);
    check_pin(32'(req), 32'h0);
    reg_write(gpp_pkg::OFS_EVT_STATUS, 32'h3);
    settle(1);
    check_pin(32'(irq), 32'h0);
    @(posedge clk_sys);
    ext_a <= 4'ha;
    settle(4);
    check_read(gpp_pkg::OFS_IRQ_SC, 32'h02);
    end_test("edge");

    reg_write(gpp_pkg::OFS_IRQ_SC, 32'h00);
    @(posedge clk_sys);
    ext_a <= 4'hb;
    settle(4);
    @(posedge clk_sys);
    ext_a <= 4'ha;
    settle(4);
    check_pin(32'({req, irq}), 32'h1);
    check_read(gpp_pkg::OFS_IRQ_SC, 32'h08);
    reg_write(gpp_pkg::OFS_EVT_MASK, 32'h0);
    settle(1);
    check_pin(32'(irq), 32'h0);
    reg_write(gpp_pkg::OFS_EVT_STATUS, 32'h3);
    reg_write(gpp_pkg::OFS_IRQ_SC, 32'h04);
    check_read(gpp_pkg::OFS_IRQ_SC, 32'h00);
    end_test("mask");

    reg_write(gpp_pkg::OFS_PIN_SEL, 32'h2);
    reg_write(gpp_pkg::OFS_EDGE_SEL, 32'h2);
    reg_write(gpp_pkg::OFS_IRQ_SC, 32'h03);
    settle(4);
    check_pin(32'(req), 32'h1);
    reg_write(gpp_pkg::OFS_IRQ_SC, 32'h07);
    check_read(gpp_pkg::OFS_IRQ_SC, 32'h0b);
    @(posedge clk_sys);
    ext_a <= 4'h8;
    settle(4);
    reg_write(gpp_pkg::OFS_IRQ_SC, 32'h07);
    check_read(gpp_pkg::OFS_IRQ_SC, 32'h03);
    end_test("level");

    reg_write(gpp_pkg::OFS_IRQ_SC, 32'h02);
    @(posedge clk_sys);
    ext_a <= 4'ha;
    settle(4);
    check_read(gpp_pkg::OFS_IRQ_SC, 32'h0a);
    end_test("rise");
    complete_run();
  end
endmodule
